// ===== core/spr_map.svh
// Purpose: Offsets, fields, resets and timing counts of the sync port receive framer.
// Assumes: 200 MHz core clock, Avalon-MM register bus with 32-bit data.
// Notes: Included by the rate generator, the framer and the bench; the package does not include it.
// Contract
// - Synchronous data travels as 8-bit characters clocked by an outside bit clock.
// - Sender changes bits on rising clock edge; receiver samples on falling edge.
// - Framing mode off selects character synchronisation from idle.
// - Framing mode on selects bit synchronisation from idle.
// - Character mode locks byte boundary on ASCII SYN 16 hex.
// - Character mode also locks on a configured EBCDIC SYN value.
// - Bit mode locks byte boundary on HDLC flag 7E hex.
// - Two independent internal rate clocks, each set by a three-bit field.
// - Port rate selectable 150 to 19200 bps in eight steps or external.
// - Per-port receive and transmit selectors pick clock A, clock B or external.
// - Output choice and pin enables decide which rate clock drives which line.
// - After lock every 8 bits form a character; leading SYNs are dropped.
// - Character mode ends block on ETX or DLE ETX (7 bits), passes two more.
// - DCD deassertion ends the current transmission in every mode.
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH

// ======================================================================
// Register map
`define SPR_REG_CTRL 5'h00
`define SPR_REG_CLK 5'h04
`define SPR_REG_STAT 5'h08
`define SPR_REG_RXD 5'h0C
// ======================================================================
// Field positions
`define SPR_CTRL_MODE 0
`define SPR_CTRL_DLE 1
`define SPR_CTRL_EBC_LO 8
`define SPR_CLK_RATE_A_LO 0
`define SPR_CLK_RATE_B_LO 3
`define SPR_CLK_HRX_LO 6
`define SPR_CLK_HTX_LO 8
`define SPR_CLK_TRX_LO 10
`define SPR_CLK_TTX_LO 12
`define SPR_CLK_OUT_CHOICE 14
`define SPR_CLK_PIN_A 15
`define SPR_CLK_PIN_B 16
`define SPR_CLK_PIN_C 17
`define SPR_RXD_VALID 8
// ======================================================================
// Reset values
`define SPR_CTRL_RST 32'h0000_1600
`define SPR_CLK_RST 32'h0000_2A3F
// ======================================================================
// Character codes
`define SPR_ASCII_SYN 8'h16
`define SPR_HDLC_FLAG 8'h7E
`define SPR_ABORT_IDLE 8'hFF
`define SPR_ETX 7'h03
`define SPR_DLE 7'h10
// ======================================================================
// Timing
`define SPR_CLK_HZ 200000000
`define SPR_TOP_BPS 19200
`define SPR_TOP_HALF (`SPR_CLK_HZ / (2 * `SPR_TOP_BPS))

`endif

// ===== core/spr_pkg.sv
// Purpose: Types shared by the sync port receive framer files.
// Assumes: Constants live in spr_map.svh.
// Notes: Nothing here is imported; users write spr_pkg::name.
package spr_pkg;

	typedef enum logic [2:0] {
		SPR_HUNT  = 3'b001,
		SPR_DATA  = 3'b010,
		SPR_TRAIL = 3'b100
	} spr_state_t;

	// Clock source selector codes.
	typedef enum logic [1:0] {
		SPR_SRC_A   = 2'h0,
		SPR_SRC_B   = 2'h1,
		SPR_SRC_EXT = 2'h2,
		SPR_SRC_OFF = 2'h3
	} spr_src_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} spr_char_t;

endpackage : spr_pkg

// ===== core/spr_rate_gen.sv
// Purpose: One internal rate clock with eight settable rates.
// Assumes: top_half_in is the half period, in core cycles, of the fastest rate.
// Notes: Each step down halves the rate, so the half period doubles.
`timescale 1ns/1ps
`include "spr_map.svh"

module spr_rate_gen #(
	parameter int CNT_W = 20
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// Setting
	input  wire logic [2:0]       rate_sel_in,
	input  wire logic [CNT_W-1:0] top_half_in,
	// Rate clock
	output logic                  rate_clk_out
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] limit;

	// Setting 7 is the fastest rate, setting 0 the slowest.
	assign limit = CNT_W'((top_half_in << (3'd7 - rate_sel_in)) - 1'b1);

	// ======================================================================
	// Divider
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q        <= '0;
			rate_clk_out <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q        <= '0;
			rate_clk_out <= ~rate_clk_out;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// ======================================================================
	// Checks
	property p_rate_toggle;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_q < limit) |=> $stable(rate_clk_out);
	endproperty
	a_rate_toggle: assert property (p_rate_toggle)
		else $error("rate clock toggled before its half period ended");

	property p_rate_flip;
		@(posedge clk_in) disable iff (rst_in)
		(cnt_q >= limit) |=> (rate_clk_out != $past(rate_clk_out)) && (cnt_q == '0);
	endproperty
	a_rate_flip: assert property (p_rate_flip)
		else $error("rate clock did not toggle at end of half period");

endmodule : spr_rate_gen

// ===== core/spr_rx_framer.sv
// Purpose: Sync port receive framer with rate clocks and clock routing.
// Assumes: Port pins are asynchronous to clk_in; bus master follows Avalon-MM.
// Notes: Data is taken LSB first; sampled on the falling edge of the receive clock.
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "spr_map.svh"

module spr_rx_framer #(
	parameter int CNT_W    = 20,
	parameter int TOP_HALF = `SPR_TOP_HALF
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	// Synchronous port pins
	input  wire logic        term_rx_clk_in,
	input  wire logic        term_rx_data_in,
	input  wire logic        dcd_in,
	input  wire logic        host_rx_ext_clk_in,
	input  wire logic        host_tx_ext_clk_in,
	input  wire logic        term_tx_ext_clk_in,
	// Routed clocks
	output logic             host_rx_clk_out,
	output logic             host_tx_clk_out,
	output logic             term_tx_clk_out,
	output logic             clock_out_pin_a_out,
	output logic             clock_out_pin_b_out,
	output logic             clock_out_pin_c_out,
	// Received characters
	output logic [7:0]       rx_char_out,
	output logic             rx_char_stb_out
);

	// ======================================================================
	// Pin synchronisers
	localparam int NS = 6;
	logic [NS-1:0] pin_s1_q;
	logic [NS-1:0] pin_s2_q;
	logic          rxclk_prev_q;
	logic          dcd_prev_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {term_tx_ext_clk_in, host_tx_ext_clk_in, host_rx_ext_clk_in,
			             dcd_in, term_rx_data_in, term_rx_clk_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ======================================================================
	// Configuration registers
	logic [31:0] ctrl_q;
	logic [31:0] clkcfg_q;
	logic        framing_mode_select;
	logic [7:0]  ebcdic_syn;
	logic        dle_etx_en;
	logic [1:0]  term_rx_clock_source_sel;

	assign framing_mode_select      = ctrl_q[`SPR_CTRL_MODE];
	assign dle_etx_en               = ctrl_q[`SPR_CTRL_DLE];
	assign ebcdic_syn               = ctrl_q[`SPR_CTRL_EBC_LO +: 8];
	assign term_rx_clock_source_sel = clkcfg_q[`SPR_CLK_TRX_LO +: 2];

	// ======================================================================
	// Internal rate clocks
	logic internal_rate_clock_a;
	logic internal_rate_clock_b;

	spr_rate_gen #(.CNT_W(CNT_W)) spr_rate_gen_inst (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.rate_sel_in (clkcfg_q[`SPR_CLK_RATE_A_LO +: 3]),
		.top_half_in (CNT_W'(TOP_HALF)),
		.rate_clk_out(internal_rate_clock_a)
	);

	spr_rate_gen #(.CNT_W(CNT_W)) spr_rate_gen_b_inst (
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.rate_sel_in (clkcfg_q[`SPR_CLK_RATE_B_LO +: 3]),
		.top_half_in (CNT_W'(TOP_HALF)),
		.rate_clk_out(internal_rate_clock_b)
	);

	function automatic logic sel_clk(input logic [1:0] sel, input logic ext);
		case (spr_pkg::spr_src_t'(sel))
			spr_pkg::SPR_SRC_A:   sel_clk = internal_rate_clock_a;
			spr_pkg::SPR_SRC_B:   sel_clk = internal_rate_clock_b;
			spr_pkg::SPR_SRC_EXT: sel_clk = ext;
			default:              sel_clk = 1'b0;
		endcase
	endfunction : sel_clk

	// ======================================================================
	// Clock routing
	logic chosen_out_clk;
	assign chosen_out_clk = clkcfg_q[`SPR_CLK_OUT_CHOICE] ? internal_rate_clock_b
	                                                      : internal_rate_clock_a;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			host_rx_clk_out     <= 1'b0;
			host_tx_clk_out     <= 1'b0;
			term_tx_clk_out     <= 1'b0;
			clock_out_pin_a_out <= 1'b0;
			clock_out_pin_b_out <= 1'b0;
			clock_out_pin_c_out <= 1'b0;
		end else begin
			host_rx_clk_out     <= sel_clk(clkcfg_q[`SPR_CLK_HRX_LO +: 2], pin_s2_q[3]);
			host_tx_clk_out     <= sel_clk(clkcfg_q[`SPR_CLK_HTX_LO +: 2], pin_s2_q[4]);
			term_tx_clk_out     <= sel_clk(clkcfg_q[`SPR_CLK_TTX_LO +: 2], pin_s2_q[5]);
			clock_out_pin_a_out <= clkcfg_q[`SPR_CLK_PIN_A] & chosen_out_clk;
			clock_out_pin_b_out <= clkcfg_q[`SPR_CLK_PIN_B] & chosen_out_clk;
			clock_out_pin_c_out <= clkcfg_q[`SPR_CLK_PIN_C] & chosen_out_clk;
		end
	end

	// ======================================================================
	// Bit sampling
	logic rxclk_now;
	logic bit_fire;
	logic dcd_fall;

	assign rxclk_now = sel_clk(term_rx_clock_source_sel, pin_s2_q[0]);
	assign bit_fire  = rxclk_prev_q & ~rxclk_now;
	assign dcd_fall  = dcd_prev_q & ~pin_s2_q[2];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rxclk_prev_q <= 1'b0;
			dcd_prev_q   <= 1'b0;
		end else begin
			rxclk_prev_q <= rxclk_now;
			dcd_prev_q   <= pin_s2_q[2];
		end
	end

	// ======================================================================
	// Framer
	spr_pkg::spr_state_t st_q;
	logic [7:0]          sh_q;
	logic [7:0]          sh_d;
	logic [2:0]          bitcnt_q;
	logic                leading_q;
	logic                trail_q;
	logic [6:0]          prev7_q;
	logic                byte_done;
	logic                hunt_hit;
	logic                etx_hit;
	logic                end_flag;
	logic                emit;

	function automatic logic is_sync(input logic [7:0] c);
		if (framing_mode_select) begin
			is_sync = (c == `SPR_HDLC_FLAG);
		end else begin
			is_sync = (c == `SPR_ASCII_SYN) || (c == ebcdic_syn);
		end
	endfunction : is_sync

	// New bit enters at the top: the line carries the least significant bit first.
	assign sh_d      = {pin_s2_q[1], sh_q[7:1]};
	assign hunt_hit  = bit_fire && (st_q == spr_pkg::SPR_HUNT) && is_sync(sh_d);
	assign byte_done = bit_fire && (st_q != spr_pkg::SPR_HUNT) && (bitcnt_q == 3'd7);
	assign etx_hit   = (sh_d[6:0] == `SPR_ETX) && (!dle_etx_en || prev7_q == `SPR_DLE);
	assign end_flag  = framing_mode_select && !leading_q &&
	                   (sh_d == `SPR_HDLC_FLAG || sh_d == `SPR_ABORT_IDLE);
	assign emit      = byte_done && !(leading_q && is_sync(sh_d)) && !end_flag;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q      <= spr_pkg::SPR_HUNT;
			sh_q      <= 8'hFF;
			bitcnt_q  <= 3'd0;
			leading_q <= 1'b1;
			trail_q   <= 1'b0;
			prev7_q   <= 7'h00;
		end else if (dcd_fall) begin
			st_q      <= spr_pkg::SPR_HUNT;
			leading_q <= 1'b1;
		end else if (bit_fire) begin
			sh_q     <= sh_d;
			bitcnt_q <= (st_q == spr_pkg::SPR_HUNT) ? 3'd0 : bitcnt_q + 3'd1;
			case (st_q)
				spr_pkg::SPR_HUNT: begin
					if (hunt_hit) begin
						st_q      <= spr_pkg::SPR_DATA;
						leading_q <= 1'b1;
						prev7_q   <= 7'h00;
					end
				end
				spr_pkg::SPR_DATA: begin
					if (byte_done && !(leading_q && is_sync(sh_d))) begin
						leading_q <= 1'b0;
						prev7_q   <= sh_d[6:0];
						if (end_flag) begin
							st_q <= spr_pkg::SPR_HUNT;
						end else if (!framing_mode_select && etx_hit) begin
							st_q    <= spr_pkg::SPR_TRAIL;
							trail_q <= 1'b0;
						end
					end
				end
				spr_pkg::SPR_TRAIL: begin
					if (byte_done) begin
						trail_q <= 1'b1;
						if (trail_q) begin
							st_q      <= spr_pkg::SPR_HUNT;
							leading_q <= 1'b1;
						end
					end
				end
				default: st_q <= spr_pkg::SPR_HUNT;
			endcase
		end
	end

	// ======================================================================
	// Character output
	spr_pkg::spr_char_t rxd_q;
	logic               rxd_read;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_char_out     <= 8'h00;
			rx_char_stb_out <= 1'b0;
		end else begin
			rx_char_stb_out <= emit;
			if (emit) begin
				rx_char_out <= sh_d;
			end
		end
	end

	// A new character in the same cycle as a read keeps the valid flag set.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rxd_q <= '0;
		end else if (emit) begin
			rxd_q <= '{valid: 1'b1, data: sh_d};
		end else if (rxd_read) begin
			rxd_q.valid <= 1'b0;
		end
	end

	// ======================================================================
	// Avalon-MM slave: every access completes one cycle after it is seen.
	logic acc_done;
	assign acc_done = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
	assign rxd_read = acc_done && avs_read_in && (avs_address_in == `SPR_REG_RXD);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0000_0000;
		end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b0;
			case (avs_address_in)
				`SPR_REG_CTRL: avs_readdata_out <= ctrl_q;
				`SPR_REG_CLK:  avs_readdata_out <= clkcfg_q;
				`SPR_REG_STAT: avs_readdata_out <= {27'h0, rxd_q.valid, pin_s2_q[2], st_q};
				`SPR_REG_RXD:  avs_readdata_out <= {23'h0, rxd_q.valid, rxd_q.data};
				default:       avs_readdata_out <= 32'h0000_0000;
			endcase
		end else begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q   <= `SPR_CTRL_RST;
			clkcfg_q <= `SPR_CLK_RST;
		end else if (acc_done && avs_write_in) begin
			if (avs_address_in == `SPR_REG_CTRL) begin
				ctrl_q <= avs_writedata_in & 32'h0000_FF03;
			end
			if (avs_address_in == `SPR_REG_CLK) begin
				clkcfg_q <= avs_writedata_in & 32'h0003_FFFF;
			end
		end
	end

	// ======================================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_bit_edge;
		bit_fire |-> $past(rxclk_now) && !rxclk_now;
	endproperty
	a_bit_edge: assert property (p_bit_edge)
		else $error("bit sampled away from a falling clock edge");

	property p_char_lock;
		hunt_hit && !framing_mode_select && sh_d == `SPR_ASCII_SYN && !dcd_fall
			|=> st_q == spr_pkg::SPR_DATA;
	endproperty
	a_char_lock: assert property (p_char_lock)
		else $error("ASCII SYN did not lock the receiver");

	property p_ebc_lock;
		bit_fire && st_q == spr_pkg::SPR_HUNT && !framing_mode_select &&
			sh_d == ebcdic_syn && !dcd_fall |=> st_q == spr_pkg::SPR_DATA;
	endproperty
	a_ebc_lock: assert property (p_ebc_lock)
		else $error("configured EBCDIC SYN did not lock the receiver");

	property p_flag_lock;
		bit_fire && st_q == spr_pkg::SPR_HUNT && framing_mode_select &&
			sh_d == `SPR_HDLC_FLAG && !dcd_fall |=> st_q == spr_pkg::SPR_DATA;
	endproperty
	a_flag_lock: assert property (p_flag_lock)
		else $error("HDLC flag did not lock the receiver");

	property p_char_mode_no_flag;
		bit_fire && st_q == spr_pkg::SPR_HUNT && !framing_mode_select &&
			sh_d != `SPR_ASCII_SYN && sh_d != ebcdic_syn |=> st_q == spr_pkg::SPR_HUNT;
	endproperty
	a_char_mode_no_flag: assert property (p_char_mode_no_flag)
		else $error("character mode locked on a non SYN pattern");

	property p_bit_mode_no_syn;
		bit_fire && st_q == spr_pkg::SPR_HUNT && framing_mode_select &&
			sh_d != `SPR_HDLC_FLAG |=> st_q == spr_pkg::SPR_HUNT;
	endproperty
	a_bit_mode_no_syn: assert property (p_bit_mode_no_syn)
		else $error("bit mode locked on a non flag pattern");

	property p_drop_leading;
		byte_done && leading_q && is_sync(sh_d) |=> !rx_char_stb_out;
	endproperty
	a_drop_leading: assert property (p_drop_leading)
		else $error("leading sync character was passed on");

	property p_byte_out;
		emit |=> rx_char_stb_out && rx_char_out == $past(sh_d);
	endproperty
	a_byte_out: assert property (p_byte_out)
		else $error("completed character not presented");

	property p_trail_end;
		byte_done && st_q == spr_pkg::SPR_TRAIL && trail_q && !dcd_fall
			|=> st_q == spr_pkg::SPR_HUNT ##1 !rx_char_stb_out;
	endproperty
	a_trail_end: assert property (p_trail_end)
		else $error("receiver did not rehunt after two trailing characters");

	property p_dcd_end;
		dcd_fall |=> st_q == spr_pkg::SPR_HUNT && leading_q;
	endproperty
	a_dcd_end: assert property (p_dcd_end)
		else $error("DCD drop did not end the transmission");

	property p_hunt_each_bit;
		bit_fire && st_q == spr_pkg::SPR_HUNT && !dcd_fall |=> sh_q == $past(sh_d);
	endproperty
	a_hunt_each_bit: assert property (p_hunt_each_bit)
		else $error("hunt window not advanced by the new bit");

	property p_pin_a;
		clkcfg_q[`SPR_CLK_PIN_A] ##1 clkcfg_q[`SPR_CLK_PIN_A]
			|-> clock_out_pin_a_out == $past(chosen_out_clk);
	endproperty
	a_pin_a: assert property (p_pin_a)
		else $error("pin A does not carry the chosen rate clock");

	c_lock: cover property (hunt_hit);
	c_trail: cover property (st_q == spr_pkg::SPR_TRAIL);
	c_dcd: cover property (dcd_fall && st_q == spr_pkg::SPR_DATA);
	c_read_rxd: cover property (rxd_read && rxd_q.valid);

endmodule : spr_rx_framer

// ===== tb/spr_dce_model.sv
// Purpose: Synchronous DCE that sends bytes LSB first on its own bit clock.
// Assumes: 160 ns bit period.
// Notes: The clock stands low between frames; idle data shows the inverse of the last bit.
`timescale 1ns/1ps

module spr_dce_model (
	// Port lines
	output logic dclk_out,
	output logic data_out,
	output logic dcd_out
);
	initial begin
		dclk_out = 1'b0;
		data_out = 1'b1;
		dcd_out  = 1'b1;
	end

	// ==========================================================
	// Bit sender
	task automatic send(input logic [7:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			dclk_out = 1'b1;
			data_out = v[i];
			#80;
			dclk_out = 1'b0;
			#80;
		end
		data_out = ~data_out;
	endtask : send

	task automatic set_dcd(input logic v);
		dcd_out = v;
	endtask : set_dcd
endmodule : spr_dce_model

// ===== tb/spr_rx_framer_bench.sv
// Purpose: Self-checking bench of the sync port receive framer.
// Assumes: Avalon answer comes through waitrequest; link bit clock 160 ns.
// Notes: TOP_HALF is cut to 4 so rate clock periods stay short.
`timescale 1ns/1ps
`include "spr_map.svh"

module spr_rx_framer_bench;
	localparam int TH = 4;
	logic        clk_in;
	logic        rst_in;
	logic        rd;
	logic        wr;
	logic        tx_ext;
	logic [4:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        wreq;
	logic        hrx;
	logic        htx;
	logic        ttx;
	logic        pa;
	logic        pb;
	logic        pc;
	logic [7:0]  rxc;
	logic        stb;
	logic        dclk;
	logic        ddat;
	logic        dcd;
	logic [7:0]  got [$];
	int          bad_count;
	int          cmp_count;
	int          cyc;

	spr_rx_framer #(.CNT_W(20), .TOP_HALF(TH)) spr_rx_framer_inst (
		.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .term_rx_clk_in(dclk), .term_rx_data_in(ddat),
		.dcd_in(dcd), .host_rx_ext_clk_in(tx_ext), .host_tx_ext_clk_in(tx_ext),
		.term_tx_ext_clk_in(tx_ext), .host_rx_clk_out(hrx), .host_tx_clk_out(htx),
		.term_tx_clk_out(ttx), .clock_out_pin_a_out(pa), .clock_out_pin_b_out(pb),
		.clock_out_pin_c_out(pc), .rx_char_out(rxc), .rx_char_stb_out(stb));

	spr_dce_model spr_dce_model_inst (.dclk_out(dclk), .data_out(ddat), .dcd_out(dcd));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// ==========================================================
	// Monitor and timeout
	always @(posedge clk_in) begin
		if (stb === 1'b1)
			got.push_back(rxc);
	end

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_in);
		adr  <= a;
		wdat <= d;
		rd   <= ~w;
		wr   <= w;
		// Waitrequest and read data are taken as they stood at each rising edge.
		do begin
			@(posedge clk_in);
		end while (wreq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg

	task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		check(nm, q, e);
	endtask : rchk

	task automatic tx(input logic [7:0] v);
		spr_dce_model_inst.send(v, 8);
	endtask : tx

	task automatic chars(input int n, input logic [63:0] e);
		check("count", got.size(), n);
		for (int i = 0; i < n && i < got.size(); i++)
			check("char", {24'h0, got[i]}, {24'h0, e[8*i +: 8]});
		got.delete();
	endtask : chars

	function automatic logic pick(input int w);
		case (w)
			0: return pa;
			1: return hrx;
			2: return htx;
			3: return pb;
			default: return pc;
		endcase
	endfunction : pick

	task automatic measure(input int w, input int e);
		int g;
		int n;
		g = 0;
		n = 0;
		while (pick(w) !== 1'b0 && g < 2000) begin
			@(negedge clk_in);
			g++;
		end
		while (pick(w) !== 1'b1 && g < 4000) begin
			@(negedge clk_in);
			g++;
		end
		while (pick(w) === 1'b1 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		check("half period", n, e);
	endtask : measure

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rchk("ctrl reset", `SPR_REG_CTRL, `SPR_CTRL_RST);
		rchk("clk reset", `SPR_REG_CLK, `SPR_CLK_RST);
		rchk("stat reset", `SPR_REG_STAT, 32'h0000_0009);
		wreg(5'h10, 32'hFFFF_FFFF);
		rchk("unmapped", 5'h10, 32'h0000_0000);
		wreg(`SPR_REG_CTRL, 32'hFFFF_FFFF);
		rchk("ctrl mask", `SPR_REG_CTRL, 32'h0000_FF03);
	endtask : t_regs

	task automatic t_char();
		wreg(`SPR_REG_CTRL, 32'h0000_1600);
		spr_dce_model_inst.send(8'h05, 3);
		tx(8'h16);
		tx(8'h16);
		tx(8'h5A);
		tx(8'h03);
		tx(8'h31);
		tx(8'h32);
		tx(8'h44);
		chars(4, 64'h32_31_03_5A);
		rchk("rxd", `SPR_REG_RXD, 32'h0000_0132);
		rchk("rxd clear", `SPR_REG_RXD, 32'h0000_0032);
	endtask : t_char

	task automatic t_dle();
		wreg(`SPR_REG_CTRL, 32'h0000_1602);
		tx(8'h16);
		tx(8'h03);
		tx(8'h10);
		tx(8'h83);
		tx(8'h61);
		tx(8'h62);
		tx(8'h45);
		chars(5, 64'h62_61_83_10_03);
	endtask : t_dle

	task automatic t_ebc();
		wreg(`SPR_REG_CTRL, 32'h0000_3200);
		tx(8'h32);
		tx(8'h32);
		tx(8'h77);
		tx(8'h03);
		tx(8'h01);
		tx(8'h02);
		chars(4, 64'h02_01_03_77);
	endtask : t_ebc

	task automatic t_bit();
		wreg(`SPR_REG_CTRL, 32'h0000_1601);
		tx(8'h7E);
		tx(8'h7E);
		tx(8'h16);
		tx(8'h55);
		tx(8'h7E);
		tx(8'h66);
		tx(8'h7E);
		tx(8'h12);
		tx(8'hFF);
		chars(3, 64'h12_55_16);
	endtask : t_bit

	task automatic t_dcd();
		wreg(`SPR_REG_CTRL, 32'h0000_1600);
		tx(8'h16);
		rchk("stat data", `SPR_REG_STAT, 32'h0000_001A);
		spr_dce_model_inst.send(8'h41, 4);
		spr_dce_model_inst.set_dcd(1'b0);
		repeat (10) @(posedge clk_in);
		rchk("stat dcd", `SPR_REG_STAT, 32'h0000_0011);
		spr_dce_model_inst.set_dcd(1'b1);
		tx(8'h41);
		chars(0, 64'h0);
	endtask : t_dcd

	task automatic t_rate();
		wreg(`SPR_REG_CLK, 32'h0000_A92F);
		measure(0, TH);
		measure(1, TH);
		measure(2, TH << 2);
		check("pin b off", pb, 1'b0);
		check("pin c off", pc, 1'b0);
		wreg(`SPR_REG_CLK, 32'h0003_6928);
		measure(3, TH << 2);
		measure(4, TH << 2);
		check("pin a off", pa, 1'b0);
		measure(1, TH << 7);
		// Host receive from outside, host transmit off, terminal transmit from outside.
		wreg(`SPR_REG_CLK, 32'h0000_2BBF);
		@(posedge clk_in);
		tx_ext <= 1'b1;
		repeat (6) @(posedge clk_in);
		check("term tx ext", ttx, 1'b1);
		check("host rx ext", hrx, 1'b1);
		check("host tx off", htx, 1'b0);
		tx_ext <= 1'b0;
		repeat (6) @(posedge clk_in);
		check("term tx ext", ttx, 1'b0);
		check("host rx ext", hrx, 1'b0);
	endtask : t_rate

	task automatic report_and_stop();
		$display("Counts: checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// Main sequence
	initial begin
		bad_count = 0;
		cmp_count = 0;
		cyc       = 0;
		rst_in    = 1'b1;
		rd        = 1'b0;
		wr        = 1'b0;
		adr       = 5'h00;
		wdat      = 32'h0000_0000;
		tx_ext    = 1'b0;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		t_regs();
		t_char();
		t_dle();
		t_ebc();
		t_bit();
		t_dcd();
		t_rate();
		report_and_stop();
	end
endmodule : spr_rx_framer_bench
